// [common/flkm_cfg.svh]
// Address map, lock-page layout and timing constants for the flash lock map checker
`ifndef FLKM_CFG_SVH
`define FLKM_CFG_SVH
`define FLKM_MAIN_BASE      32'h0000_0000
`define FLKM_INFO_BASE      32'h0fe0_0000
`define FLKM_UD_BASE        32'h0fe0_0000
`define FLKM_LB_BASE        32'h0fe0_4000
`define FLKM_DI_BASE        32'h0fe0_8000
`define FLKM_PAGE_BYTES     32'h0000_0200
`define FLKM_PAGE_SHIFT     9
`define FLKM_MAIN_PAGES     64
`define FLKM_MAIN_LIMIT     32'h0000_8000
`define FLKM_PLW_COUNT      2
`define FLKM_DLW_INDEX      7'h7f
`define FLKM_ULW_INDEX      7'h7e
`define FLKM_DLW_OPEN       4'hf
`define FLKM_ULW_UD_BIT     0
`define FLKM_ULW_LB_BIT     1
`define FLKM_ERASED_WORD    32'hffff_ffff
`define FLKM_WORD_ZERO      32'h0000_0000
// Device erase runs 40 ms
`define FLKM_ERASE_MS       40
`define FLKM_CLK_MHZ        250
`define FLKM_ERASE_CYCLES   (`FLKM_ERASE_MS * 1000 * `FLKM_CLK_MHZ)
`define FLKM_REG_LOCK_BASE  4'h0
`define FLKM_REG_STATUS     4'h8
`define FLKM_REG_DBG_ST     4'h9
`endif

// [common/flkm_pkg.sv]
// Types shared by the flash lock map checker files
package flkm_pkg;
    typedef enum logic [1:0] {
        FLKM_OP_NONE,
        FLKM_OP_WRITE,
        FLKM_OP_ERASE
    } flkm_op_t;

    typedef enum logic [2:0] {
        FLKM_RGN_MAIN,
        FLKM_RGN_UD,
        FLKM_RGN_LB,
        FLKM_RGN_DI,
        FLKM_RGN_NONE
    } flkm_rgn_t;

    typedef enum logic [1:0] {
        FLKM_PWR_RUN,
        FLKM_PWR_SLEEP,
        FLKM_PWR_DEEP,
        FLKM_PWR_OFF
    } flkm_pwr_t;
endpackage

// [logic/flkm_decode.sv]
// Address decoder: region, page index and word index within page
`timescale 1ns/100ps
`include "flkm_cfg.svh"
module flkm_decode (
    // Address in
    input  wire logic [31:0]       addr_i,
    // Decoded
    output flkm_pkg::flkm_rgn_t    rgn_o,
    output logic      [5:0]        page_o,
    output logic      [6:0]        word_o
);
    import flkm_pkg::*;

    always_comb begin
        page_o = addr_i[`FLKM_PAGE_SHIFT +: 6];
        word_o = addr_i[8:2];
        // Each information page is one 512 byte window at its own base
        if (addr_i < `FLKM_MAIN_LIMIT) begin
            rgn_o = FLKM_RGN_MAIN;
        end else if ((addr_i & ~(`FLKM_PAGE_BYTES - 32'h1)) == `FLKM_UD_BASE) begin
            rgn_o = FLKM_RGN_UD;
        end else if ((addr_i & ~(`FLKM_PAGE_BYTES - 32'h1)) == `FLKM_LB_BASE) begin
            rgn_o = FLKM_RGN_LB;
        end else if ((addr_i & ~(`FLKM_PAGE_BYTES - 32'h1)) == `FLKM_DI_BASE) begin
            rgn_o = FLKM_RGN_DI;
        end else begin
            rgn_o = FLKM_RGN_NONE;
        end
    end
endmodule

// [logic/flkm_check.sv]
// Flash lock map checker: decodes requests, holds lock words, grants or refuses
`timescale 1ns/100ps
`include "flkm_cfg.svh"
// How it works
// - Main at zero, information at high base
// - 512 byte pages, up to 64 main
// - Lock page writable; erase only from debug
// - Software may erase/write user page unless locked
// - Device erase keeps user page contents
// - Debug allowed only when lock nibble all ones
// - User lock word bit0 user, bit1 lock page
// - Each page lock word covers 32 pages
// - Zero lock bit blocks erase and write
// - Debug-port device erase unlocks all bits
// - Authentication port reachable only from debug
// - Flash access only in run or sleep
// - Processor and DMA both may access
// - Device erase clears every main page
// - Device erase clears all four lock words
// - Lock page erase reopens debug after reset
module flkm_check #(
    parameter int unsigned ERASE_CYCLES = `FLKM_ERASE_CYCLES
) (
    // Clock, reset, enable
    input  wire logic                 mclk_i,
    input  wire logic                 resetn_i,
    input  wire logic                 ce_i,
    // Access request from processor, DMA or debug
    input  wire logic                 req_i,
    input  wire logic [1:0]           req_master_i,
    input  flkm_pkg::flkm_op_t        req_op_i,
    input  wire logic [31:0]          req_addr_i,
    input  wire logic [31:0]          req_wdata_i,
    input  wire logic                 req_read_i,
    // Power state, comes from another domain
    input  flkm_pkg::flkm_pwr_t       pwr_state_i,
    // Device erase from the authentication access port
    input  wire logic                 auth_erase_i,
    // Chip reset seen by lock logic (latch debug lock)
    input  wire logic                 lock_reload_i,
    // Register port
    input  wire logic [3:0]           reg_addr_i,
    input  wire logic [31:0]          reg_wdata_i,
    input  wire logic                 reg_wr_i,
    input  wire logic                 reg_rd_i,
    output logic      [31:0]          reg_rdata_o,
    // Verdict
    output logic                      grant_o,
    output logic                      deny_o,
    output logic      [31:0]          rdata_o,
    output logic                      debug_en_o,
    output logic                      erase_busy_o,
    output logic                      main_erase_o,
    output logic                      lock_page_erase_o
);
    import flkm_pkg::*;

    localparam logic [1:0] MST_CPU = 2'h0;
    localparam logic [1:0] MST_DMA = 2'h1;
    localparam logic [1:0] MST_DBG = 2'h2;

    typedef enum logic [1:0] {
        FLKM_ST_IDLE,
        FLKM_ST_ERASE,
        FLKM_ST_LOCKS
    } flkm_state_t;

    typedef struct packed {
        flkm_state_t  st;
        logic [31:0]  cnt;
        logic [31:0]  plw0;
        logic [31:0]  plw1;
        logic [31:0]  user_page_lock_word;
        logic [31:0]  debug_lock_word;
        logic         dbg_en;
        logic [1:0]   pwr_s1;
        logic [1:0]   pwr_s2;
        logic         aer_s1;
        logic         aer_s2;
        logic         aer_d;
        logic         grant;
        logic         deny;
        logic [31:0]  rdata;
        logic [31:0]  reg_rdata;
        logic         main_erase;
        logic         lb_erase;
        logic         wipe_flag;
        logic         busy;
    } flkm_state_s_t;

    flkm_state_s_t s_r;
    flkm_state_s_t s_nxt;

    flkm_rgn_t    rgn;
    logic [5:0]   page;
    logic [6:0]   word;

    flkm_decode u_decode (
        .addr_i (req_addr_i),
        .rgn_o  (rgn),
        .page_o (page),
        .word_o (word)
    );

    // Lock bit of one main page from the two page lock words
    function automatic logic page_open(input logic [5:0] pg, input logic [31:0] w0,
                                       input logic [31:0] w1);
        logic [31:0] w;
        w = pg[5] ? w1 : w0;
        return w[pg[4:0]];
    endfunction

    // Word read back from the lock page
    function automatic logic [31:0] lb_word(input logic [6:0] idx, input flkm_state_s_t s);
        logic [31:0] v;
        v = `FLKM_ERASED_WORD;
        if (idx == `FLKM_DLW_INDEX) begin
            v = s.debug_lock_word;
        end else if (idx == `FLKM_ULW_INDEX) begin
            v = s.user_page_lock_word;
        end else if (idx == 7'h00) begin
            v = s.plw0;
        end else if (idx == 7'h01) begin
            v = s.plw1;
        end
        return v;
    endfunction

    logic pwr_ok;
    logic aer_rise;
    logic wr_allow;
    logic er_allow;
    logic is_sw;

    always_comb begin
        s_nxt = s_r;
        pwr_ok = (s_r.pwr_s2 == FLKM_PWR_RUN) || (s_r.pwr_s2 == FLKM_PWR_SLEEP);
        aer_rise = s_r.aer_s2 && !s_r.aer_d;
        is_sw = (req_master_i == MST_CPU) || (req_master_i == MST_DMA);
        wr_allow = 1'b0;
        er_allow = 1'b0;

        s_nxt.pwr_s1 = pwr_state_i;
        s_nxt.pwr_s2 = s_r.pwr_s1;
        // Erase request only enters through the debug pin path
        s_nxt.aer_s1 = auth_erase_i;
        s_nxt.aer_s2 = s_r.aer_s1;
        s_nxt.aer_d = s_r.aer_s2;
        s_nxt.grant = 1'b0;
        s_nxt.deny = 1'b0;
        s_nxt.main_erase = 1'b0;
        s_nxt.lb_erase = 1'b0;

        case (rgn)
            FLKM_RGN_MAIN: begin
                wr_allow = page_open(page, s_r.plw0, s_r.plw1);
                er_allow = wr_allow;
            end
            FLKM_RGN_UD: begin
                wr_allow = s_r.user_page_lock_word[`FLKM_ULW_UD_BIT];
                er_allow = wr_allow && is_sw;
            end
            FLKM_RGN_LB: begin
                wr_allow = s_r.user_page_lock_word[`FLKM_ULW_LB_BIT];
                er_allow = (req_master_i == MST_DBG) && s_r.user_page_lock_word[`FLKM_ULW_LB_BIT];
            end
            default: begin
                wr_allow = 1'b0;
                er_allow = 1'b0;
            end
        endcase

        case (s_r.st)
            FLKM_ST_IDLE: begin
                if (aer_rise) begin
                    s_nxt.st = FLKM_ST_ERASE;
                    s_nxt.cnt = 32'h0000_0000;
                end else if (req_i) begin
                    // Refusals keep the array untouched
                    if (!pwr_ok) begin
                        s_nxt.deny = 1'b1;
                    end else if (req_read_i) begin
                        s_nxt.grant = (rgn != FLKM_RGN_NONE);
                        s_nxt.deny = (rgn == FLKM_RGN_NONE);
                        s_nxt.rdata = (rgn == FLKM_RGN_LB) ? lb_word(word, s_r)
                                                           : `FLKM_ERASED_WORD;
                    end else if (req_op_i == FLKM_OP_WRITE) begin
                        s_nxt.grant = wr_allow;
                        s_nxt.deny = !wr_allow;
                        // Flash writes only clear bits
                        if (wr_allow && rgn == FLKM_RGN_LB) begin
                            if (word == `FLKM_DLW_INDEX) s_nxt.debug_lock_word = s_r.debug_lock_word & req_wdata_i;
                            if (word == `FLKM_ULW_INDEX) s_nxt.user_page_lock_word = s_r.user_page_lock_word & req_wdata_i;
                            if (word == 7'h00) s_nxt.plw0 = s_r.plw0 & req_wdata_i;
                            if (word == 7'h01) s_nxt.plw1 = s_r.plw1 & req_wdata_i;
                        end
                    end else if (req_op_i == FLKM_OP_ERASE) begin
                        s_nxt.grant = er_allow;
                        s_nxt.deny = !er_allow;
                        if (er_allow && rgn == FLKM_RGN_LB) begin
                            s_nxt.plw0 = `FLKM_ERASED_WORD;
                            s_nxt.plw1 = `FLKM_ERASED_WORD;
                            s_nxt.user_page_lock_word = `FLKM_ERASED_WORD;
                            s_nxt.debug_lock_word = `FLKM_ERASED_WORD;
                        end
                    end else begin
                        s_nxt.deny = 1'b1;
                    end
                end
            end
            FLKM_ST_ERASE: begin
                // Array wipe runs for the full erase time; requests refused meanwhile
                s_nxt.main_erase = 1'b1;
                s_nxt.deny = req_i;
                s_nxt.cnt = s_r.cnt + 32'h0000_0001;
                if (s_r.cnt >= ERASE_CYCLES - 1) begin
                    s_nxt.st = FLKM_ST_LOCKS;
                end
            end
            FLKM_ST_LOCKS: begin
                // Lock page last so a cut erase leaves the part locked
                s_nxt.lb_erase = 1'b1;
                s_nxt.plw0 = `FLKM_ERASED_WORD;
                s_nxt.plw1 = `FLKM_ERASED_WORD;
                s_nxt.user_page_lock_word = `FLKM_ERASED_WORD;
                s_nxt.debug_lock_word = `FLKM_ERASED_WORD;
                s_nxt.wipe_flag = 1'b1;
                s_nxt.deny = req_i;
                s_nxt.st = FLKM_ST_IDLE;
            end
            default: begin
                s_nxt.st = FLKM_ST_IDLE;
            end
        endcase
        // Own flop so the busy pin carries no decode glitches
        s_nxt.busy = (s_nxt.st != FLKM_ST_IDLE);

        // Debug gate only follows the lock word at a reload
        if (lock_reload_i) begin
            s_nxt.dbg_en = (s_r.debug_lock_word[3:0] == `FLKM_DLW_OPEN);
        end

        // Register port: preload of lock words from the array, status reads
        if (reg_wr_i && s_r.st == FLKM_ST_IDLE) begin
            if (reg_addr_i == `FLKM_REG_LOCK_BASE) s_nxt.plw0 = reg_wdata_i;
            if (reg_addr_i == `FLKM_REG_LOCK_BASE + 4'h1) s_nxt.plw1 = reg_wdata_i;
            if (reg_addr_i == `FLKM_REG_LOCK_BASE + 4'h2) s_nxt.user_page_lock_word = reg_wdata_i;
            if (reg_addr_i == `FLKM_REG_LOCK_BASE + 4'h3) s_nxt.debug_lock_word = reg_wdata_i;
        end
        if (reg_wr_i && reg_addr_i == `FLKM_REG_STATUS && reg_wdata_i[2]) begin
            s_nxt.wipe_flag = (s_r.st == FLKM_ST_LOCKS);
        end
        s_nxt.reg_rdata = `FLKM_WORD_ZERO;
        if (reg_rd_i) begin
            case (reg_addr_i)
                4'h0: s_nxt.reg_rdata = s_r.plw0;
                4'h1: s_nxt.reg_rdata = s_r.plw1;
                4'h2: s_nxt.reg_rdata = s_r.user_page_lock_word;
                4'h3: s_nxt.reg_rdata = s_r.debug_lock_word;
                `FLKM_REG_STATUS: s_nxt.reg_rdata = {29'h0, s_r.wipe_flag, pwr_ok,
                                                    s_r.st != FLKM_ST_IDLE};
                `FLKM_REG_DBG_ST: s_nxt.reg_rdata = {31'h0, s_r.dbg_en};
                default: s_nxt.reg_rdata = `FLKM_WORD_ZERO;
            endcase
        end
    end

    always_ff @(posedge mclk_i) begin
        if (!resetn_i) begin
            s_r <= '0;
            s_r.st <= FLKM_ST_IDLE;
            s_r.plw0 <= `FLKM_ERASED_WORD;
            s_r.plw1 <= `FLKM_ERASED_WORD;
            s_r.user_page_lock_word <= `FLKM_ERASED_WORD;
            s_r.debug_lock_word <= `FLKM_ERASED_WORD;
            s_r.dbg_en <= 1'b1;
            s_r.rdata <= `FLKM_ERASED_WORD;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    assign grant_o = s_r.grant;
    assign deny_o = s_r.deny;
    assign rdata_o = s_r.rdata;
    assign reg_rdata_o = s_r.reg_rdata;
    assign debug_en_o = s_r.dbg_en;
    assign erase_busy_o = s_r.busy;
    assign main_erase_o = s_r.main_erase;
    assign lock_page_erase_o = s_r.lb_erase;
endmodule

// [dv/flkm_check_assertions.sv]
// Port checker for the flash lock map checker
`timescale 1ns/100ps
module flkm_check_sva #(
    parameter int unsigned ERASE_CYCLES = 20
) (
    input  wire logic           mclk_i,
    input  wire logic           resetn_i,
    input  wire logic           ce_i,
    input  wire logic           req_i,
    input  flkm_pkg::flkm_pwr_t pwr_state_i,
    input  wire logic           lock_reload_i,
    input  logic                grant_o,
    input  logic                deny_o,
    input  logic                debug_en_o,
    input  logic                erase_busy_o,
    input  logic                main_erase_o,
    input  logic                lock_page_erase_o
);
    import flkm_pkg::*;
    logic [31:0] run_r;
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);
    // Length of the current main erase run
    always_ff @(posedge mclk_i) begin
        run_r <= (!resetn_i || !main_erase_o) ? 32'h0 : run_r + 32'h1;
    end
    chk_one_answer: assert property (req_i && ce_i && !erase_busy_o |=> grant_o ^ deny_o)
        else $error("request not answered by exactly one verdict");
    chk_no_spurious: assert property (grant_o || deny_o |-> $past(req_i && ce_i))
        else $error("verdict without request");
    chk_power_deny: assert property (req_i && ce_i && pwr_state_i == FLKM_PWR_OFF
        && $past(pwr_state_i, 2) == FLKM_PWR_OFF && $past(pwr_state_i, 3) == FLKM_PWR_OFF
        |=> deny_o) else $error("access granted while powered down");
    chk_busy_deny: assert property (erase_busy_o && req_i && ce_i |=> deny_o)
        else $error("access not refused during device erase");
    chk_main_busy: assert property (main_erase_o |-> erase_busy_o)
        else $error("main erase outside busy");
    chk_erase_len: assert property ($fell(main_erase_o) |-> run_r == ERASE_CYCLES)
        else $error("main erase length wrong");
    chk_lb_after: assert property (lock_page_erase_o |-> $past(main_erase_o) ##1
        !lock_page_erase_o) else $error("lock page erase pulse misplaced");
    chk_debug_hold: assert property ($changed(debug_en_o) |-> $past(lock_reload_i))
        else $error("debug enable changed without reload");
endmodule

bind flkm_check flkm_check_sva #(.ERASE_CYCLES(ERASE_CYCLES)) u_sva (
    .mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i), .req_i(req_i),
    .pwr_state_i(pwr_state_i), .lock_reload_i(lock_reload_i), .grant_o(grant_o),
    .deny_o(deny_o), .debug_en_o(debug_en_o), .erase_busy_o(erase_busy_o),
    .main_erase_o(main_erase_o), .lock_page_erase_o(lock_page_erase_o)
);

// [dv/flkm_master.sv]
// Bus master model: processor, DMA or debug request source
`timescale 1ns/100ps
module flkm_master (
    // Clock
    input  wire logic          mclk_i,
    // Request out
    output logic               req_o,
    output logic        [1:0]  master_o,
    output flkm_pkg::flkm_op_t op_o,
    output logic        [31:0] addr_o,
    output logic        [31:0] wdata_o,
    output logic               read_o,
    // Answer in
    input  wire logic          grant_i,
    input  wire logic          deny_i,
    input  wire logic   [31:0] rdata_i
);
    import flkm_pkg::*;
    initial begin
        req_o = 1'b0;
        master_o = 2'h3;
        op_o = FLKM_OP_NONE;
        addr_o = 32'h0;
        wdata_o = 32'h0;
        read_o = 1'b0;
    end
    // Request held one edge, answer taken just after that same edge
    task automatic xfer(input logic [1:0] m, input flkm_op_t op, input logic rd,
                        input logic [31:0] a, input logic [31:0] d,
                        output logic g, output logic n, output logic [31:0] q);
        @(posedge mclk_i);
        req_o <= 1'b1;
        master_o <= m;
        op_o <= op;
        read_o <= rd;
        addr_o <= a;
        wdata_o <= d;
        @(posedge mclk_i);
        req_o <= 1'b0;
        op_o <= FLKM_OP_NONE;
        read_o <= 1'b0;
        // Released lines must not keep looking valid
        addr_o <= ~a;
        wdata_o <= ~d;
        #1;
        g = grant_i;
        n = deny_i;
        q = rdata_i;
    endtask
endmodule

// [dv/test_flash_lock_map_check.sv]
// Self-checking bench for the flash lock map checker
`timescale 1ns/100ps
`include "flkm_cfg.svh"
module test_flash_lock_map_check;
    import flkm_pkg::*;
    localparam logic [1:0] CPU = 2'h0;
    localparam logic [1:0] DMA = 2'h1;
    localparam logic [1:0] DBG = 2'h2;
    localparam logic [31:0] USER_PAGE_LOCK_WORD = `FLKM_LB_BASE + 32'h1f8;
    localparam logic [31:0] DEBUG_LOCK_WORD = `FLKM_LB_BASE + 32'h1fc;
    logic mclk_i, resetn_i, ce_i, req_i, req_read_i, auth_erase_i, lock_reload_i;
    logic reg_wr_i, reg_rd_i, grant_o, deny_o, debug_en_o, erase_busy_o;
    logic main_erase_o, lock_page_erase_o;
    logic [1:0] req_master_i;
    logic [3:0] reg_addr_i;
    logic [31:0] req_addr_i, req_wdata_i, reg_wdata_i, reg_rdata_o, rdata_o;
    flkm_op_t req_op_i;
    flkm_pwr_t pwr_state_i;
    int miscompares = 0;
    int comparisons = 0;

    flkm_check #(.ERASE_CYCLES(20)) u_dut (
        .mclk_i(mclk_i), .resetn_i(resetn_i), .ce_i(ce_i), .req_i(req_i),
        .req_master_i(req_master_i), .req_op_i(req_op_i), .req_addr_i(req_addr_i),
        .req_wdata_i(req_wdata_i), .req_read_i(req_read_i), .pwr_state_i(pwr_state_i),
        .auth_erase_i(auth_erase_i), .lock_reload_i(lock_reload_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .grant_o(grant_o), .deny_o(deny_o), .rdata_o(rdata_o),
        .debug_en_o(debug_en_o), .erase_busy_o(erase_busy_o), .main_erase_o(main_erase_o),
        .lock_page_erase_o(lock_page_erase_o));
    flkm_master u_mst (
        .mclk_i(mclk_i), .req_o(req_i), .master_o(req_master_i), .op_o(req_op_i),
        .addr_o(req_addr_i), .wdata_o(req_wdata_i), .read_o(req_read_i),
        .grant_i(grant_o), .deny_i(deny_o), .rdata_i(rdata_o));

    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end
    task automatic wrap_up();
        $display("TB done: %0d comparisons, %0d miscompares", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        #20000;
        miscompares++;
        wrap_up();
    end
    task automatic chk_b(input logic got, input logic exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t flag got %b exp %b", $time, got, exp);
        end
    endtask
    task automatic chk_w(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t word got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic acc(input logic [1:0] m, input flkm_op_t op, input logic [31:0] a,
                       input logic [31:0] d, input logic ok);
        logic g, n;
        logic [31:0] q;
        u_mst.xfer(m, op, 1'b0, a, d, g, n, q);
        chk_b(g, ok);
        chk_b(n, !ok);
    endtask
    task automatic rd_flash(input logic [31:0] a, input logic [31:0] exp);
        logic g, n;
        logic [31:0] q;
        u_mst.xfer(CPU, FLKM_OP_NONE, 1'b1, a, 32'h0, g, n, q);
        chk_b(g, 1'b1);
        chk_w(q, exp);
    endtask
    task automatic reg_acc(input logic wr, input logic [3:0] a, input logic [31:0] d,
                           output logic [31:0] q);
        @(posedge mclk_i);
        reg_wr_i <= wr;
        reg_rd_i <= !wr;
        reg_addr_i <= a;
        reg_wdata_i <= d;
        @(posedge mclk_i);
        reg_wr_i <= 1'b0;
        reg_rd_i <= 1'b0;
        #1;
        q = reg_rdata_o;
    endtask
    task automatic reload();
        @(posedge mclk_i);
        lock_reload_i <= 1'b1;
        @(posedge mclk_i);
        lock_reload_i <= 1'b0;
        #1;
    endtask
    task automatic t_map();
        chk_b(debug_en_o, 1'b1);
        acc(CPU, FLKM_OP_WRITE, `FLKM_MAIN_BASE, 32'h1, 1'b1);
        acc(DMA, FLKM_OP_ERASE, 32'h7e00, 32'h0, 1'b1);
        acc(CPU, FLKM_OP_WRITE, `FLKM_MAIN_LIMIT, 32'h1, 1'b0);
        acc(CPU, FLKM_OP_ERASE, `FLKM_UD_BASE, 32'h0, 1'b1);
        rd_flash(DEBUG_LOCK_WORD, `FLKM_ERASED_WORD);
    endtask
    task automatic t_lock();
        logic [31:0] q;
        acc(CPU, FLKM_OP_ERASE, `FLKM_LB_BASE, 32'h0, 1'b0);
        acc(CPU, FLKM_OP_WRITE, `FLKM_LB_BASE, 32'hffff_fffe, 1'b1);
        acc(DMA, FLKM_OP_WRITE, 32'h0, 32'h1, 1'b0);
        acc(CPU, FLKM_OP_ERASE, 32'h0, 32'h0, 1'b0);
        acc(CPU, FLKM_OP_WRITE, 32'h3e00, 32'h1, 1'b1);
        acc(DBG, FLKM_OP_WRITE, `FLKM_LB_BASE + 32'h4, 32'h7fff_ffff, 1'b1);
        acc(CPU, FLKM_OP_WRITE, 32'h7e00, 32'h1, 1'b0);
        acc(CPU, FLKM_OP_WRITE, 32'h4000, 32'h1, 1'b1);
        acc(CPU, FLKM_OP_WRITE, USER_PAGE_LOCK_WORD, 32'hffff_fffe, 1'b1);
        acc(CPU, FLKM_OP_WRITE, `FLKM_UD_BASE, 32'h1, 1'b0);
        rd_flash(USER_PAGE_LOCK_WORD, 32'hffff_fffe);
        reg_acc(1'b0, 4'h0, 32'h0, q);
        chk_w(q, 32'hffff_fffe);
    endtask
    task automatic t_debug();
        acc(DBG, FLKM_OP_WRITE, DEBUG_LOCK_WORD, 32'hffff_fff0, 1'b1);
        chk_b(debug_en_o, 1'b1);
        reload();
        chk_b(debug_en_o, 1'b0);
    endtask
    task automatic t_power();
        for (int i = 0; i < 4; i++) begin
            @(posedge mclk_i);
            pwr_state_i <= flkm_pwr_t'(i);
            repeat (3) @(posedge mclk_i);
            acc(DMA, FLKM_OP_WRITE, 32'h200, 32'h1, i < 2);
        end
        @(posedge mclk_i);
        pwr_state_i <= FLKM_PWR_RUN;
        repeat (3) @(posedge mclk_i);
    endtask
    task automatic t_ce();
        logic g, n;
        logic [31:0] q;
        // Frozen block must not take an otherwise grantable request
        @(posedge mclk_i);
        ce_i <= 1'b0;
        u_mst.xfer(CPU, FLKM_OP_WRITE, 1'b0, 32'h200, 32'h1, g, n, q);
        chk_b(g, 1'b0);
        chk_b(n, 1'b0);
        @(posedge mclk_i);
        ce_i <= 1'b1;
    endtask
    task automatic t_wipe();
        int n;
        logic [31:0] q;
        @(posedge mclk_i);
        auth_erase_i <= 1'b1;
        n = 0;
        while (erase_busy_o !== 1'b1 && n < 20) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        acc(CPU, FLKM_OP_WRITE, 32'h200, 32'h1, 1'b0);
        chk_b(main_erase_o, 1'b1);
        n = 0;
        while (erase_busy_o !== 1'b0 && n < 100) begin
            @(posedge mclk_i);
            #1;
            n++;
        end
        chk_b(erase_busy_o, 1'b0);
        chk_b(lock_page_erase_o, 1'b1);
        @(posedge mclk_i);
        auth_erase_i <= 1'b0;
        for (int i = 0; i < 4; i++) begin
            reg_acc(1'b0, i[3:0], 32'h0, q);
            chk_w(q, `FLKM_ERASED_WORD);
        end
        reg_acc(1'b0, `FLKM_REG_STATUS, 32'h0, q);
        chk_w(q, 32'h6);
        reg_acc(1'b1, `FLKM_REG_STATUS, 32'h4, q);
        reg_acc(1'b0, `FLKM_REG_STATUS, 32'h0, q);
        chk_w(q, 32'h2);
        reg_acc(1'b0, 4'h5, 32'h0, q);
        reload();
        chk_b(debug_en_o, 1'b1);
        acc(CPU, FLKM_OP_WRITE, 32'h0, 32'h1, 1'b1);
        acc(CPU, FLKM_OP_WRITE, `FLKM_UD_BASE, 32'h1, 1'b1);
        rd_flash(USER_PAGE_LOCK_WORD, `FLKM_ERASED_WORD);
    endtask
    initial begin
        resetn_i = 1'b0;
        ce_i = 1'b1;
        auth_erase_i = 1'b0;
        lock_reload_i = 1'b0;
        reg_wr_i = 1'b0;
        reg_rd_i = 1'b0;
        reg_addr_i = 4'h0;
        reg_wdata_i = 32'h0;
        pwr_state_i = FLKM_PWR_RUN;
        repeat (3) @(posedge mclk_i);
        resetn_i <= 1'b1;
        t_map();
        t_lock();
        t_debug();
        t_power();
        t_ce();
        t_wipe();
        wrap_up();
    end
endmodule
